// >>> inc/tsn_defs.svh
// Constants for the temperature sensor serial slave
`ifndef TSN_DEFS_SVH
`define TSN_DEFS_SVH
`define TSN_ADDR_DEFAULT   7'h4d
`define TSN_ADDR_VARIANTS  8
`define TSN_CMD_TEMP       8'h00
`define TSN_CMD_CONFIG     8'h01
`define TSN_CFG_STANDBY    7
`define TSN_CFG_READY      6
`define TSN_FIRST_CONV_MS  250
`define TSN_CONV_PERIOD_US 125000
`define TSN_CLK_MHZ        25
`define TSN_BIT_LAST       3'h7
`define TSN_TEMP_RESET     8'h00
`endif

// >>> inc/tsn_pkg.sv
// Types for the temperature sensor serial slave
package tsn_pkg;
   typedef enum logic [2:0] {
      TSN_IDLE,
      TSN_RX,
      TSN_ACK,
      TSN_TX,
      TSN_TX_ACK,
      TSN_IGNORE
   } tsn_phase_t;

   typedef enum logic [1:0] {
      TSN_BYTE_ADDR,
      TSN_BYTE_CMD,
      TSN_BYTE_DATA
   } tsn_byte_t;
endpackage

// >>> rtl/tsn_regfile.sv
// Register store for command pointer, configuration and result
`include "tsn_defs.svh"
module tsn_regfile (
   input  wire logic       ref_clk,
   input  wire logic       reset,
   input  wire logic       wr_cmd,
   input  wire logic       wr_data,
   input  wire logic [7:0] wdata,
   input  wire logic       conv_done,
   input  wire logic [7:0] conv_value,
   output logic      [7:0] rdata,
   output logic            standby
);
   typedef struct packed {
      logic [7:0] cmd;
      logic [7:0] config_reg;
      logic [7:0] temp;
      logic [7:0] rdata;
   } tsn_rf_state_t;

   tsn_rf_state_t r;
   tsn_rf_state_t next_r;

   always_comb begin
      next_r = r;
      if (wr_cmd) begin
         next_r.cmd = wdata;
      end
      if (wr_data && r.cmd == `TSN_CMD_CONFIG) begin
         next_r.config_reg[`TSN_CFG_STANDBY] = wdata[`TSN_CFG_STANDBY];
      end
      // Frozen result in standby: a conv_done can still arrive in its first cycle and is ignored
      if (conv_done && !r.config_reg[`TSN_CFG_STANDBY]) begin
         next_r.temp = conv_value;
         next_r.config_reg[`TSN_CFG_READY] = 1'b1;
      end
      // Read path never waits on the converter
      next_r.rdata = (r.cmd == `TSN_CMD_CONFIG) ? r.config_reg : r.temp;
   end

   always_ff @(posedge ref_clk) begin
      if (reset) begin
         r <= '0;
      end else begin
         r <= next_r;
      end
   end

   assign rdata   = r.rdata;
   assign standby = r.config_reg[`TSN_CFG_STANDBY];
endmodule

// >>> rtl/tsn_slave.sv
// Temperature sensor core with two-wire serial slave port
// Overview of operation
// - Converts temperature repeatedly into result register
// - Result readable anytime without waiting
// - Address one of eight, fixed build-time
// - Standby halts converter, freezes result
// - Serial port works fully in standby
// - Standby bit: 0 normal, 1 standby
// - Default slave address binary 1001101
// - First conversion ready within 250 ms
// - Data line shared; device drives ack/reads
// - Acknowledge only matching address, else silent
// - Address bit eight: 1 read, 0 write
// - All bytes shifted MSB first
// - Acknowledge written byte after storing it
`include "tsn_defs.svh"
module tsn_slave #(
   parameter logic [2:0]  ADDR_SEL       = 3'h0, // Build-time address variant
   parameter int unsigned CONV_PERIOD_US = `TSN_CONV_PERIOD_US,
   parameter int unsigned CONV_CYCLES    = CONV_PERIOD_US * `TSN_CLK_MHZ
) (
   input  wire logic       ref_clk,
   input  wire logic       reset,
   input  wire logic       scl_in,
   input  wire logic       sda_in,
   output logic            sda_out,
   output logic            sda_oe,
   input  wire logic [7:0] temp_sample,
   output logic            standby,
   output logic            data_ready
);
   // ==========================================================
   // Address selection
   // ==========================================================
   // Variant 0 is the default; others xor the low three bits
   localparam logic [6:0] OWN_ADDR = `TSN_ADDR_DEFAULT ^ {4'h0, ADDR_SEL};

   // ==========================================================
   // State
   // ==========================================================
   typedef struct packed {
      logic [1:0]         scl_sync;
      logic [1:0]         sda_sync;
      logic               scl_d;
      logic               sda_d;
      tsn_pkg::tsn_phase_t phase;
      tsn_pkg::tsn_byte_t  kind;
      logic [2:0]         bit_cnt;
      logic               byte_full;
      logic [7:0]         shreg;
      logic               is_read;
      logic               drive_low;
      logic               sda_oe;
      logic [31:0]        conv_cnt;
      logic               conv_done;
      logic [7:0]         conv_value;
      logic               standby;
      logic               data_ready;
      logic               wr_cmd;
      logic               wr_data;
      logic [7:0]         wdata;
   } tsn_state_t;

   tsn_state_t s;
   tsn_state_t next_s;

   logic [7:0] rf_rdata;
   logic       rf_standby;

   tsn_regfile u_regfile (
      .ref_clk    (ref_clk),
      .reset      (reset),
      .wr_cmd     (s.wr_cmd),
      .wr_data    (s.wr_data),
      .wdata      (s.wdata),
      .conv_done  (s.conv_done),
      .conv_value (s.conv_value),
      .rdata      (rf_rdata),
      .standby    (rf_standby)
   );

   logic scl;
   logic sda;
   logic scl_rise;
   logic scl_fall;
   logic start_cond;
   logic stop_cond;

   // Only the second sync stage is looked at
   assign scl        = s.scl_sync[1];
   assign sda        = s.sda_sync[1];
   assign scl_rise   = scl && !s.scl_d;
   assign scl_fall   = !scl && s.scl_d;
   assign start_cond = scl && s.scl_d && s.sda_d && !sda;
   assign stop_cond  = scl && s.scl_d && !s.sda_d && sda;

   // ==========================================================
   // Next state
   // ==========================================================
   always_comb begin
      next_s           = s;
      next_s.scl_sync  = {s.scl_sync[0], scl_in};
      next_s.sda_sync  = {s.sda_sync[0], sda_in};
      next_s.scl_d     = scl;
      next_s.sda_d     = sda;
      next_s.wr_cmd    = 1'b0;
      next_s.wr_data   = 1'b0;
      next_s.conv_done = 1'b0;
      next_s.standby   = rf_standby;
      next_s.sda_oe    = s.drive_low;

      // Converter: halted in standby, resumes counting after
      if (!rf_standby) begin
         if (s.conv_cnt >= CONV_CYCLES - 1) begin
            next_s.conv_cnt   = '0;
            next_s.conv_done  = 1'b1;
            next_s.conv_value = temp_sample;
            next_s.data_ready = 1'b1;
         end else begin
            next_s.conv_cnt = s.conv_cnt + 32'h1;
         end
      end

      // Port runs irrespective of standby
      case (s.phase)
         tsn_pkg::TSN_IDLE: begin
            next_s.drive_low = 1'b0;
         end
         tsn_pkg::TSN_RX: begin
            if (scl_rise) begin
               next_s.shreg     = {s.shreg[6:0], sda};
               next_s.bit_cnt   = s.bit_cnt + 3'h1;
               next_s.byte_full = (s.bit_cnt == `TSN_BIT_LAST);
            end
            // The fall right after START must not end a byte
            if (scl_fall && s.byte_full) begin
               next_s.phase     = tsn_pkg::TSN_ACK;
               next_s.drive_low = 1'b1;
               next_s.byte_full = 1'b0;
               if (s.kind == tsn_pkg::TSN_BYTE_ADDR) begin
                  if (s.shreg[7:1] != OWN_ADDR) begin
                     next_s.phase     = tsn_pkg::TSN_IGNORE;
                     next_s.drive_low = 1'b0;
                  end
                  next_s.is_read = s.shreg[0];
               end else if (s.kind == tsn_pkg::TSN_BYTE_CMD) begin
                  next_s.wr_cmd = 1'b1;
                  next_s.wdata  = s.shreg;
               end else begin
                  next_s.wr_data = 1'b1;
                  next_s.wdata   = s.shreg;
               end
            end
         end
         tsn_pkg::TSN_ACK: begin
            if (scl_fall) begin
               next_s.bit_cnt = '0;
               if (s.kind == tsn_pkg::TSN_BYTE_ADDR && s.is_read) begin
                  next_s.phase     = tsn_pkg::TSN_TX;
                  next_s.shreg     = rf_rdata;
                  next_s.drive_low = !rf_rdata[7];
               end else begin
                  next_s.phase     = tsn_pkg::TSN_RX;
                  next_s.drive_low = 1'b0;
                  next_s.kind      = (s.kind == tsn_pkg::TSN_BYTE_ADDR) ? tsn_pkg::TSN_BYTE_CMD
                                                                        : tsn_pkg::TSN_BYTE_DATA;
               end
            end
         end
         tsn_pkg::TSN_TX: begin
            if (scl_fall) begin
               if (s.bit_cnt == `TSN_BIT_LAST) begin
                  next_s.phase     = tsn_pkg::TSN_TX_ACK;
                  next_s.drive_low = 1'b0;
               end else begin
                  next_s.shreg     = {s.shreg[6:0], 1'b0};
                  next_s.drive_low = !s.shreg[6];
                  next_s.bit_cnt   = s.bit_cnt + 3'h1;
               end
            end
         end
         tsn_pkg::TSN_TX_ACK: begin
            // Master nack ends the read; ack repeats the byte
            if (scl_rise) begin
               next_s.phase = sda ? tsn_pkg::TSN_IGNORE : tsn_pkg::TSN_ACK;
            end
         end
         tsn_pkg::TSN_IGNORE: begin
            next_s.drive_low = 1'b0;
         end
         default: begin
            next_s.phase     = tsn_pkg::TSN_IDLE;
            next_s.drive_low = 1'b0;
         end
      endcase

      if (start_cond) begin
         next_s.phase     = tsn_pkg::TSN_RX;
         next_s.kind      = tsn_pkg::TSN_BYTE_ADDR;
         next_s.bit_cnt   = '0;
         next_s.byte_full = 1'b0;
         next_s.drive_low = 1'b0;
      end else if (stop_cond) begin
         next_s.phase     = tsn_pkg::TSN_IDLE;
         next_s.drive_low = 1'b0;
      end
   end

   // ==========================================================
   // Registers
   // ==========================================================
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         s          <= '0;
         s.scl_sync <= 2'h3;
         s.sda_sync <= 2'h3;
         s.scl_d    <= 1'b1;
         s.sda_d    <= 1'b1;
         s.phase    <= tsn_pkg::TSN_IDLE;
         s.kind     <= tsn_pkg::TSN_BYTE_ADDR;
      end else begin
         s <= next_s;
      end
   end

   // Open drain: only ever pulls low
   assign sda_out    = 1'b0;
   assign sda_oe     = s.sda_oe;
   assign standby    = s.standby;
   assign data_ready = s.data_ready;
endmodule

// >>> testbench/tsn_slave_properties.sv
// Port checker for the temperature sensor serial slave
module tsn_slave_properties #(
   parameter int unsigned CONV_CYCLES = 50
) (
   input wire logic       ref_clk,
   input wire logic       reset,
   input wire logic       scl_in,
   input wire logic       sda_in,
   input wire logic       sda_out,
   input wire logic       sda_oe,
   input wire logic [7:0] temp_sample,
   input wire logic       standby,
   input wire logic       data_ready
);
   // ==========
   // Cycles since reset
   logic [15:0] age;
   logic [15:0] next_age;
   always_comb next_age = (age == 16'hffff) ? age : age + 16'h1;
   always_ff @(posedge ref_clk) age <= reset ? 16'h0 : next_age;
   default clocking @(posedge ref_clk); endclocking
   default disable iff (reset);
   sequence s_oe_held;
      $stable(sda_oe)[*3];
   endsequence
   a_drive_low_only: assert property (sda_out == 1'b0) else $error("sda_out high");
   a_reset_quiet: assert property (disable iff (1'b0) reset |=> !sda_oe && !standby && !data_ready)
      else $error("outputs active after reset");
   a_first_result: assert property (age == 16'(CONV_CYCLES + 8) |-> data_ready)
      else $error("first result late");
   a_ready_sticky: assert property (data_ready |=> data_ready) else $error("ready dropped");
   a_oe_scl_low: assert property ($changed(sda_oe) |-> !scl_in) else $error("sda moved with scl high");
   a_oe_held_high: assert property ($rose(scl_in) |=> s_oe_held) else $error("sda moved in high");
   a_ack_length: assert property ($rose(sda_oe) |=> sda_oe[*5]) else $error("ack too short");
   a_store_then_ack: assert property ($changed(standby) |-> ##[0:12] sda_oe)
      else $error("no ack after store");
   a_halt_in_standby: assert property ($rose(data_ready) |-> !standby) else $error("converted in standby");
endmodule

// >>> testbench/tsn_host.sv
// Bus master model for the serial clock and data pins
module tsn_host (
   input  wire logic ref_clk,
   input  wire logic sda,
   output logic      scl,
   output logic      pull
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [8:0] res;
   event       done;
   initial begin
      scl = 1'b1;
      pull = 1'b0;
   end
   // ==========
   // One bit: 6 cycles low, 2 high
   task bit1(input logic b, output logic r);
      @(negedge ref_clk);
      pull = ~b;
      repeat (5) @(negedge ref_clk);
      scl = 1'b1;
      @(negedge ref_clk);
      r = sda;
      @(negedge ref_clk);
      scl = 1'b0;
   endtask
   // Start when s, else stop; waits out the slave's release
   task cond(input logic s);
      @(negedge ref_clk);
      pull = ~s;
      repeat (6) @(negedge ref_clk);
      scl = 1'b1;
      repeat (3) @(negedge ref_clk);
      pull = s;
      repeat (3) @(negedge ref_clk);
      if (s) begin
         scl = 1'b0;
      end
   endtask
   task xfer(input logic [7:0] d);
      logic a;
      for (int i = 7; i >= 0; i--) begin
         bit1(d[i], res[i]);
      end
      bit1(1'b1, a);
      res[8] = ~a;
      -> done;
   endtask
endmodule

// >>> testbench/testbench.sv
// Self-checking bench for the temperature sensor serial slave
module testbench;
   timeunit 1ns;
   timeprecision 1ns;
   localparam int unsigned CONV = 50;
   localparam logic [6:0]  ADDR = 7'h4d;
   localparam logic [2:0]  ALT_SEL = 3'h5;
   logic       ref_clk = 1'b0;
   logic       reset = 1'b1;
   logic [7:0] temp_sample = 8'h00;
   logic       scl, pull, sda, sda_oe, sda_out, standby, data_ready;
   logic       sda_oe_b, sda_out_b, standby_b, data_ready_b;
   logic [8:0] exp_q[$];
   logic [7:0] t_old, t_new;
   integer     seed = 20882;
   int         failures = 0;
   int         n_compared = 0;
   int         cycles = 0;
   always #20 ref_clk = ~ref_clk;
   // Pulled-up shared data wire
   assign sda = ~(pull | (sda_oe & ~sda_out) | (sda_oe_b & ~sda_out_b));
   tsn_slave #(.CONV_CYCLES(CONV)) uut (.ref_clk(ref_clk), .reset(reset), .scl_in(scl),
      .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe), .temp_sample(temp_sample), .standby(standby),
      .data_ready(data_ready));
   // Second sensor on the same bus, built at another address variant
   tsn_slave #(.ADDR_SEL(ALT_SEL), .CONV_CYCLES(CONV)) uut_b (.ref_clk(ref_clk), .reset(reset), .scl_in(scl),
      .sda_in(sda), .sda_out(sda_out_b), .sda_oe(sda_oe_b), .temp_sample(temp_sample), .standby(standby_b),
      .data_ready(data_ready_b));
   tsn_host host (.ref_clk(ref_clk), .sda(sda), .scl(scl), .pull(pull));
   task chk(input string nm, input logic [8:0] e, input logic [8:0] g);
      n_compared++;
      if (g !== e) begin
         failures++;
         $display("[ERR] %s exp %h got %h", nm, e, g);
      end
   endtask
   task end_of_test;
      if (failures == 0 && n_compared > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   // Each byte notes {ack, line bits}
   task send(input logic [7:0] d, input logic [8:0] e);
      exp_q.push_back(e);
      host.xfer(d);
   endtask
   task read_reg(input logic [7:0] cmd, input logic [7:0] e);
      host.cond(1'b1);
      send({ADDR, 1'b0}, {1'b1, ADDR, 1'b0});
      send(cmd, {1'b1, cmd});
      host.cond(1'b1);
      send({ADDR, 1'b1}, {1'b1, ADDR, 1'b1});
      send(8'hff, {1'b0, e});
      host.cond(1'b0);
   endtask
   task write_cfg(input logic [7:0] d);
      host.cond(1'b1);
      send({ADDR, 1'b0}, {1'b1, ADDR, 1'b0});
      send(8'h01, 9'h101);
      send(d, {1'b1, d});
      host.cond(1'b0);
   endtask
   always @(host.done) chk("byte", exp_q.pop_front(), host.res);
   always @(negedge ref_clk) begin
      cycles++;
      if (cycles == 20000) begin
         failures++;
         end_of_test;
      end
   end
   // ==========
   // Main sequence
   initial begin
      repeat (8) @(negedge ref_clk);
      reset = 1'b0;
      @(negedge ref_clk);
      chk("data_ready", 9'h0, {8'h0, data_ready});
      t_old = 8'($random(seed));
      t_new = t_old ^ {1'b1, 7'($random(seed))};
      temp_sample = t_old;
      repeat (CONV + 10) @(negedge ref_clk);
      chk("data_ready", 9'h1, {8'h0, data_ready});
      chk("data_ready_b", 9'h1, {8'h0, data_ready_b});
      read_reg(8'h00, t_old);
      for (int k = 1; k < 8; k++) begin
         host.cond(1'b1);
         send({ADDR ^ 7'(k), 1'b0}, {(3'(k) == ALT_SEL), ADDR ^ 7'(k), 1'b0});
         host.cond(1'b0);
      end
      write_cfg(8'h80);
      chk("standby", 9'h1, {8'h0, standby});
      chk("standby_b", 9'h0, {8'h0, standby_b});
      temp_sample = t_new;
      repeat (3 * CONV) @(negedge ref_clk);
      read_reg(8'h00, t_old);
      read_reg(8'h01, 8'hc0);
      write_cfg(8'h00);
      chk("standby", 9'h0, {8'h0, standby});
      repeat (3 * CONV) @(negedge ref_clk);
      read_reg(8'h00, t_new);
      repeat (10) @(negedge ref_clk);
      end_of_test;
   end
endmodule
bind tsn_slave tsn_slave_properties #(.CONV_CYCLES(CONV_CYCLES)) chk_i (.ref_clk(ref_clk), .reset(reset),
   .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe), .temp_sample(temp_sample),
   .standby(standby), .data_ready(data_ready));
